// File: lpts_pkg.sv
// Package of constants and types for the low-power tag sense window block
package lpts_pkg;
   // ----------------------------------------------------------------
   // Register indices; the byte address on paddr is four times the index
   // ----------------------------------------------------------------
   localparam logic [7:0]  IDX_OPTIONS    = 8'h3a;
   localparam logic [7:0]  IDX_Q_LOWER    = 8'h3f;
   localparam logic [7:0]  IDX_Q_UPPER    = 8'h40;
   localparam logic [7:0]  IDX_I_LOWER    = 8'h41;
   localparam logic [7:0]  IDX_I_RESULT   = 8'h42;
   localparam logic [7:0]  IDX_Q_RESULT   = 8'h43;
   localparam logic [7:0]  IDX_IRQ_STATUS = 8'h50;
   localparam logic [7:0]  IDX_IRQ_MASK   = 8'h51;
   localparam logic [7:0]  IDX_CONTROL    = 8'h52;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int          THR_MSB        = 5;
   localparam int          PAIR_LO        = 6;
   localparam int          PAIR_HI        = 7;
   localparam int          SUPPRESS_BIT   = 6;
   localparam int          OPT_FULL_DRIVE = 3;
   localparam int          OPT_FILTER     = 2;
   localparam int          OPT_Q_CHANGING = 1;
   localparam int          OPT_I_CHANGING = 0;
   localparam int          IRQ_SENSE_BIT  = 0;
   localparam int          IRQ_DONE_BIT   = 1;
   localparam int          CTRL_START_BIT = 0;
   localparam int          CTRL_BUSY_BIT  = 1;
   // ----------------------------------------------------------------
   // Reset values and timing
   // ----------------------------------------------------------------
   localparam logic [5:0]  THR_RESET      = 6'h00;
   localparam logic [7:0]  BYTE_RESET     = 8'h00;
   localparam logic [1:0]  IRQ_RESET      = 2'h0;
   localparam int          CLK_HZ         = 10_000_000;
   localparam real         FILT_WINDOW_US = 4.72;
   // Longest time rounds down: 4.72 us at 10 MHz is 47 cycles
   localparam int          FILT_CYCLES    = int'($floor(FILT_WINDOW_US * CLK_HZ / 1.0e6));
   localparam int          RAW_CYCLES     = 1;
   localparam logic [5:0]  FILT_CNT       = 6'(FILT_CYCLES);
   localparam logic [5:0]  RAW_CNT        = 6'(RAW_CYCLES);
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [5:0] i_value;
      logic [5:0] q_value;
   } lpts_sample_type;
   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_DECIDE} lpts_state_type;
endpackage

// File: lpts_window.sv
// Low-power tag sense window evaluation with APB register slave
`timescale 1ns/10ps
module lpts_window
   import lpts_pkg::*;
#(
   parameter bit            NEWEST_REV = 1'b1
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [5:0]  adc_i,
   input  wire logic [5:0]  adc_q,
   output logic             full_drive,
   output logic             sense_active,
   output logic             irq
);

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic [5:0]      q_lower_r;
   logic [5:0]      q_upper_r;
   logic [5:0]      i_lower_r;
   logic [5:0]      i_upper_r;
   logic [5:0]      i_meas_r;
   logic [5:0]      q_meas_r;
   logic            suppress_r;
   logic            full_drive_r;
   logic            filter_r;
   logic            i_chg_r;
   logic            q_chg_r;
   logic [1:0]      irq_stat_r;
   logic [1:0]      irq_mask_r;
   lpts_sample_type sync1_r;
   lpts_sample_type sync2_r;
   lpts_sample_type first_r;
   lpts_state_type  state_r;
   logic [5:0]      cnt_r;
   logic            run_i_chg_r;
   logic            run_q_chg_r;
   logic            wr_en;
   logic            rd_en;
   logic [7:0]      idx;
   logic            start;
   logic            out_window;
   logic [7:0]      rd_byte;
   logic            mapped;

   // Unsigned six-bit outside-window
   function automatic logic outside(input logic [5:0] v, input logic [5:0] lo,
                                    input logic [5:0] hi);
      outside = (v > hi) || (v < lo);
   endfunction

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   // Zero-wait slave: every access completes in its first access cycle
   assign idx     = paddr[9:2];
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite && mapped;
   assign rd_en   = psel && penable && !pwrite;
   assign start   = wr_en && (idx == IDX_CONTROL) && pwdata[CTRL_START_BIT]
                    && (state_r == ST_IDLE);
   assign pslverr = psel && penable && !mapped;

   // Options register decodes only on the newest revision
   always_comb begin
      mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
      unique case (idx)
         IDX_Q_LOWER, IDX_Q_UPPER, IDX_I_LOWER,
         IDX_I_RESULT, IDX_Q_RESULT, IDX_IRQ_STATUS,
         IDX_IRQ_MASK, IDX_CONTROL: mapped = mapped;
         IDX_OPTIONS: mapped = mapped && NEWEST_REV;
         default:     mapped = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Threshold registers
   // ----------------------------------------------------------------
   // Each register carries its own threshold plus a pair of I upper bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_lower_r <= THR_RESET;
         q_upper_r <= THR_RESET;
         i_lower_r <= THR_RESET;
         i_upper_r <= THR_RESET;
      end else if (wr_en) begin
         if (idx == IDX_Q_LOWER) begin
            q_lower_r       <= pwdata[THR_MSB:0];
            i_upper_r[5:4]  <= pwdata[PAIR_HI:PAIR_LO];
         end
         if (idx == IDX_Q_UPPER) begin
            q_upper_r       <= pwdata[THR_MSB:0];
            i_upper_r[3:2]  <= pwdata[PAIR_HI:PAIR_LO];
         end
         if (idx == IDX_I_LOWER) begin
            i_lower_r       <= pwdata[THR_MSB:0];
            i_upper_r[1:0]  <= pwdata[PAIR_HI:PAIR_LO];
         end
      end
   end

   // Option control bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         full_drive_r <= 1'b0;
         filter_r     <= 1'b0;
      end else if (wr_en && idx == IDX_OPTIONS) begin
         full_drive_r <= pwdata[OPT_FULL_DRIVE];
         filter_r     <= pwdata[OPT_FILTER];
      end
   end

   // Drive request is meaningful only while a run is sampling
   assign full_drive   = full_drive_r && (state_r == ST_SAMPLE);
   assign sense_active = (state_r == ST_SAMPLE);

   // ----------------------------------------------------------------
   // Converter input synchroniser
   // ----------------------------------------------------------------
   // Two flops stand before any logic reads a converter word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= '{i_value: adc_i, q_value: adc_q};
         sync2_r <= sync1_r;
      end
   end

   // ----------------------------------------------------------------
   // Detection run sequencer
   // ----------------------------------------------------------------
   // Raw mode takes one sample; filtered mode watches 47 cycles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         cnt_r   <= 6'h00;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (start) begin
                  state_r <= ST_SAMPLE;
                  cnt_r   <= filter_r ? FILT_CNT : RAW_CNT;
               end
            end
            ST_SAMPLE: begin
               cnt_r <= cnt_r - 6'h01;
               if (cnt_r == 6'h01) begin
                  state_r <= ST_DECIDE;
               end
            end
            ST_DECIDE: state_r <= ST_IDLE;
            // The fourth code is unused; fall back to idle if ever reached
            default:   state_r <= ST_IDLE;
         endcase
      end
   end

   // Track first sample and any change across the window
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_r     <= '0;
         run_i_chg_r <= 1'b0;
         run_q_chg_r <= 1'b0;
      end else if (start) begin
         first_r     <= sync2_r;
         run_i_chg_r <= 1'b0;
         run_q_chg_r <= 1'b0;
      end else if (state_r == ST_SAMPLE) begin
         if (sync2_r.i_value != first_r.i_value) run_i_chg_r <= 1'b1;
         if (sync2_r.q_value != first_r.q_value) run_q_chg_r <= 1'b1;
      end
   end

   // Results latch at run end; filtered mode takes the window's last
   // value, which only counts as settled when no change was seen
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         i_meas_r <= THR_RESET;
         q_meas_r <= THR_RESET;
         i_chg_r  <= 1'b0;
         q_chg_r  <= 1'b0;
      end else if (state_r == ST_SAMPLE && cnt_r == 6'h01) begin
         i_meas_r <= filter_r ? sync2_r.i_value : first_r.i_value;
         q_meas_r <= filter_r ? sync2_r.q_value : first_r.q_value;
         // Meaningless without filter, so kept clear then
         i_chg_r  <= filter_r && (run_i_chg_r ||
                     sync2_r.i_value != first_r.i_value);
         q_chg_r  <= filter_r && (run_q_chg_r ||
                     sync2_r.q_value != first_r.q_value);
      end
   end

   // Suppression set by software, released at next run start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         suppress_r <= 1'b0;
      end else if (start) begin
         suppress_r <= 1'b0;
      end else if (wr_en && idx == IDX_Q_RESULT && pwdata[SUPPRESS_BIT]) begin
         suppress_r <= 1'b1;
      end
   end

   // Window decision on the freshly latched results
   assign out_window = outside(i_meas_r, i_lower_r, i_upper_r)
                    || outside(q_meas_r, q_lower_r, q_upper_r);

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   // Hardware set wins over a write-one clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_r <= IRQ_RESET;
      end else begin
         for (int b = 0; b < 2; b++) begin
            if (wr_en && idx == IDX_IRQ_STATUS && pwdata[b]) begin
               irq_stat_r[b] <= 1'b0;
            end
         end
         if (state_r == ST_DECIDE && out_window && !suppress_r) begin
            irq_stat_r[IRQ_SENSE_BIT] <= 1'b1;
         end
         if (state_r == ST_DECIDE) begin
            irq_stat_r[IRQ_DONE_BIT] <= 1'b1;
         end
      end
   end

   // Interrupt mask, one enable per status flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_r <= IRQ_RESET;
      end else if (wr_en && idx == IDX_IRQ_MASK) begin
         irq_mask_r <= pwdata[1:0];
      end
   end

   // Suppression also masks a flag already pending
   assign irq = |(irq_stat_r & irq_mask_r & {1'b1, !suppress_r});

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   // Reserved bits read back as zero
   always_comb begin
      rd_byte = BYTE_RESET;
      unique case (idx)
         IDX_Q_LOWER:    rd_byte = {i_upper_r[5:4], q_lower_r};
         IDX_Q_UPPER:    rd_byte = {i_upper_r[3:2], q_upper_r};
         IDX_I_LOWER:    rd_byte = {i_upper_r[1:0], i_lower_r};
         IDX_I_RESULT:   rd_byte = {2'h0, i_meas_r};
         IDX_Q_RESULT:   rd_byte = {1'b0, suppress_r, q_meas_r};
         IDX_OPTIONS:    rd_byte = NEWEST_REV ? {4'h0, full_drive_r, filter_r,
                                    q_chg_r, i_chg_r} : BYTE_RESET;
         IDX_IRQ_STATUS: rd_byte = {6'h00, irq_stat_r};
         IDX_IRQ_MASK:   rd_byte = {6'h00, irq_mask_r};
         IDX_CONTROL:    rd_byte = {6'h00, state_r != ST_IDLE, 1'b0};
         default:        rd_byte = BYTE_RESET;
      endcase
   end

   // Captured in the setup cycle so the word stands through the access phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence run_ends;
      state_r == ST_DECIDE;
   endsequence

   // Filtered window: sense stays up from the cycle after start
   sequence filt_sampling;
      sense_active [*8];
   endsequence

   // Interrupt path
   chk_sense_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
      run_ends and out_window && !suppress_r |=> irq_stat_r[IRQ_SENSE_BIT])
      else $error("sense flag not set on out-of-window result");
   chk_suppress_blocks: assert property (@(posedge clk) disable iff (!rst_n)
      suppress_r && !irq_stat_r[IRQ_SENSE_BIT] |=> !irq_stat_r[IRQ_SENSE_BIT])
      else $error("flag raised while suppressed");
   chk_rearm_start: assert property (@(posedge clk) disable iff (!rst_n)
      start |=> !suppress_r) else $error("suppression kept over start");
   // Run timing: 47 filtered or one raw sampling cycle, then one decide cycle
   chk_filt_window: assert property (@(posedge clk) disable iff (!rst_n)
      start && filter_r |=> filt_sampling ##40 run_ends)
      else $error("filtered window length wrong");
   chk_raw_window: assert property (@(posedge clk) disable iff (!rst_n)
      start && !filter_r |=> sense_active ##1 state_r == ST_DECIDE)
      else $error("raw window length wrong");
   chk_chg_filter: assert property (@(posedge clk) disable iff (!rst_n)
      state_r == ST_DECIDE && !filter_r |-> !i_chg_r && !q_chg_r)
      else $error("change flags set without filter");
   chk_i_upper_pair: assert property (@(posedge clk) disable iff (!rst_n)
      wr_en && idx == IDX_I_LOWER |=> i_upper_r[1:0] == $past(pwdata[PAIR_HI:PAIR_LO]))
      else $error("I upper low pair not taken");
   chk_drive_req: assert property (@(posedge clk) disable iff (!rst_n)
      sense_active |-> full_drive == full_drive_r)
      else $error("drive request wrong");
   chk_irq_out: assert property (@(posedge clk) disable iff (!rst_n)
      irq_stat_r[IRQ_DONE_BIT] && irq_mask_r[IRQ_DONE_BIT] |-> irq)
      else $error("irq output not raised");

   // Register side: split threshold writes and refused reads
   chk_q_lower_pair: assert property (@(posedge clk) disable iff (!rst_n)
      wr_en && idx == IDX_Q_LOWER |=> q_lower_r == $past(pwdata[THR_MSB:0])
      && i_upper_r[5:4] == $past(pwdata[PAIR_HI:PAIR_LO]))
      else $error("Q lower write not split");
   chk_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
      rd_en && !mapped |-> prdata == 32'h0000_0000 && pslverr)
      else $error("unmapped read not refused");

   // Status, suppression and drive
   chk_sense_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
      wr_en && idx == IDX_IRQ_STATUS && pwdata[IRQ_SENSE_BIT] && !run_ends
      |=> !irq_stat_r[IRQ_SENSE_BIT]) else $error("sense flag not cleared");
   chk_suppress_set: assert property (@(posedge clk) disable iff (!rst_n)
      wr_en && idx == IDX_Q_RESULT && pwdata[SUPPRESS_BIT] |=> suppress_r)
      else $error("suppression not taken");
   chk_suppress_gate: assert property (@(posedge clk) disable iff (!rst_n)
      suppress_r && !irq_mask_r[IRQ_DONE_BIT] |-> !irq)
      else $error("irq raised while suppressed");
   chk_drive_idle: assert property (@(posedge clk) disable iff (!rst_n)
      !sense_active |-> !full_drive)
      else $error("drive request outside window");

   // Results and counting
   chk_result_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !(state_r == ST_SAMPLE && cnt_r == 6'h01) |=> $stable(i_meas_r) && $stable(q_meas_r))
      else $error("result changed outside run end");
   chk_start_refused: assert property (@(posedge clk) disable iff (!rst_n)
      state_r == ST_SAMPLE && cnt_r != 6'h01 |=> state_r == ST_SAMPLE
      && cnt_r == $past(cnt_r) - 6'h01) else $error("window count disturbed");

endmodule // lpts_window

// File: lpts_adc_model.sv
// Behavioural model of the I/Q measurement converters facing the sense window
`timescale 1ns/10ps
module lpts_adc_model
   import lpts_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            sense_active,
   input  wire lpts_sample_type level,
   input  wire logic            wobble_i,
   input  wire logic            wobble_q,
   output logic           [5:0] adc_i,
   output logic           [5:0] adc_q
);
   logic tog_r;
   // Phase steps only inside a window, so a quiet channel never drifts between runs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tog_r <= 1'b0;
      end else if (sense_active) begin
         tog_r <= ~tog_r;
      end
   end
   // A noisy channel flips its lowest bit every cycle of the window
   assign adc_i = level.i_value ^ {5'h00, wobble_i & tog_r};
   assign adc_q = level.q_value ^ {5'h00, wobble_q & tog_r};
endmodule // lpts_adc_model

// File: lpts_window_tb_top.sv
// Self-checking testbench of the low-power tag sense window block
`timescale 1ns/10ps
module lpts_window_tb_top
   import lpts_pkg::*;
;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, pslverr_old;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, prdata_old;
   logic [5:0] adc_i, adc_q;
   logic full_drive, sense_active, irq, wob_i, wob_q, err_v, err_old;
   logic [7:0] rd_v, rd_old;
   lpts_sample_type level;
   int miscompares, n_compared, cycles, cyc;
   logic drv;
   // ------------------------------------------------------------
   // Design, older-revision twin and converter model
   // ------------------------------------------------------------
   lpts_window #(.NEWEST_REV(1'b1)) lpts_window_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .adc_i(adc_i), .adc_q(adc_q),
      .full_drive(full_drive), .sense_active(sense_active), .irq(irq));
   // Twin shares the bus; only its read answers are looked at
   lpts_window #(.NEWEST_REV(1'b0)) lpts_window_old_inst (.clk(clk), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata_old), .pready(), .pslverr(pslverr_old), .adc_i(adc_i), .adc_q(adc_q),
      .full_drive(), .sense_active(), .irq());
   lpts_adc_model lpts_adc_model_inst (.clk(clk), .rst_n(rst_n), .sense_active(sense_active),
      .level(level), .wobble_i(wob_i), .wobble_q(wob_q), .adc_i(adc_i), .adc_q(adc_q));
   // ------------------------------------------------------------
   // Compare, bus and run helpers
   // ------------------------------------------------------------
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
      end
   endtask
   // Request held from setup until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd_v = prdata[7:0];
      err_v = pslverr;
      err_old = pslverr_old;
      rd_old = prdata_old[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      check8(rd_v, exp);
   endtask
   // Start a run and count window cycles; the sense flag lands after the decide cycle
   task automatic run(input logic [5:0] i, input logic [5:0] q);
      level <= '{i_value: i, q_value: q};
      repeat (4) @(posedge clk);
      wr(IDX_CONTROL, 8'h01);
      cyc = 0;
      drv = 1'b0;
      while (cyc == 0 || sense_active) begin
         @(posedge clk);
         if (sense_active) cyc++;
         if (full_drive) drv = 1'b1;
      end
      repeat (3) @(posedge clk);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      rd(IDX_OPTIONS, 8'h00);
      check1(err_old, 1'b1);
      check8(rd_old, 8'h00);
      rd(IDX_I_RESULT, 8'h00);
      rd(IDX_Q_RESULT, 8'h00);
      check1(irq, 1'b0);
      wr(IDX_I_LOWER, 8'hc5);
      rd(IDX_I_LOWER, 8'hc5);
      wr(IDX_I_RESULT, 8'hff);
      rd(IDX_I_RESULT, 8'h00);
      wr(IDX_OPTIONS, 8'hff);
      rd(IDX_OPTIONS, 8'h0c);
      check8(rd_old, 8'h00);
      wr(IDX_OPTIONS, 8'h00);
      apb(1'b0, 8'h60, 8'h00);
      check1(err_v, 1'b1);
   endtask
   // Upper I bound 2d is split over three register pairs, most significant first
   task automatic t_window();
      logic [12:0] cases [0:6];
      cases = '{{6'h2d, 6'h10, 1'b0}, {6'h2e, 6'h10, 1'b1}, {6'h08, 6'h10, 1'b0},
                {6'h07, 6'h10, 1'b1}, {6'h20, 6'h20, 1'b0}, {6'h20, 6'h21, 1'b1},
                {6'h3f, 6'h3f, 1'b1}};
      wr(IDX_Q_LOWER, 8'h80);
      wr(IDX_Q_UPPER, 8'he0);
      wr(IDX_I_LOWER, 8'h48);
      wr(IDX_IRQ_MASK, 8'h01);
      for (int k = 0; k < 7; k++) begin
         run(cases[k][12:7], cases[k][6:1]);
         rd(IDX_I_RESULT, {2'b00, cases[k][12:7]});
         rd(IDX_Q_RESULT, {2'b00, cases[k][6:1]});
         apb(1'b0, IDX_IRQ_STATUS, 8'h00);
         check1(rd_v[IRQ_SENSE_BIT], cases[k][0]);
         check1(rd_v[IRQ_DONE_BIT], 1'b1);
         check1(irq, cases[k][0]);
         wr(IDX_IRQ_STATUS, 8'h03);
         @(posedge clk);
         check1(irq, 1'b0);
      end
   endtask
   // Mask and suppression both hide a pending flag; a new run re-arms
   task automatic t_suppress();
      run(6'h3f, 6'h10);
      check1(irq, 1'b1);
      wr(IDX_IRQ_MASK, 8'h00);
      @(posedge clk);
      check1(irq, 1'b0);
      wr(IDX_IRQ_MASK, 8'h01);
      @(posedge clk);
      check1(irq, 1'b1);
      wr(IDX_Q_RESULT, 8'h40);
      @(posedge clk);
      check1(irq, 1'b0);
      rd(IDX_Q_RESULT, 8'h50);
      wr(IDX_IRQ_STATUS, 8'h03);
      run(6'h3f, 6'h10);
      check1(irq, 1'b1);
      wr(IDX_IRQ_STATUS, 8'h03);
   endtask
   // Filtered window length, drive select and change flags per channel
   task automatic t_filter();
      wr(IDX_OPTIONS, 8'h0c);
      wob_i <= 1'b1;
      run(6'h20, 6'h20);
      check8(8'(cyc), 8'(FILT_CYCLES));
      check1(drv, 1'b1);
      rd(IDX_OPTIONS, 8'h0d);
      wob_i <= 1'b0;
      wob_q <= 1'b1;
      run(6'h20, 6'h18);
      rd(IDX_OPTIONS, 8'h0e);
      wr(IDX_OPTIONS, 8'h00);
      run(6'h20, 6'h18);
      check8(8'(cyc), 8'(RAW_CYCLES));
      check1(drv, 1'b0);
      rd(IDX_OPTIONS, 8'h00);
      wob_q <= 1'b0;
   endtask
   // Suppression set mid-run survives a refused start; then a reset mid-run
   task automatic t_midrun();
      level <= '{i_value: 6'h3f, q_value: 6'h10};
      wr(IDX_IRQ_STATUS, 8'h03);
      wr(IDX_OPTIONS, 8'h04);
      wr(IDX_CONTROL, 8'h01);
      rd(IDX_CONTROL, 8'h02);
      wr(IDX_Q_RESULT, 8'h40);
      wr(IDX_CONTROL, 8'h01);
      repeat (60) @(posedge clk);
      apb(1'b0, IDX_IRQ_STATUS, 8'h00);
      check1(rd_v[IRQ_SENSE_BIT], 1'b0);
      check1(rd_v[IRQ_DONE_BIT], 1'b1);
      check1(irq, 1'b0);
      rd(IDX_I_RESULT, 8'h3f);
      wr(IDX_CONTROL, 8'h01);
      repeat (5) @(posedge clk);
      check1(sense_active, 1'b1);
      rst_n <= 1'b0;
      @(posedge clk);
      check1(sense_active, 1'b0);
      check1(full_drive, 1'b0);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(IDX_OPTIONS, 8'h00);
      rd(IDX_I_RESULT, 8'h00);
      rd(IDX_Q_RESULT, 8'h00);
   endtask
   task automatic stop_test();
      $display("Compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Clock, hang guard and main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Whole run needs a few hundred cycles; the ceiling leaves ample margin
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         stop_test();
      end
   end
   initial begin
      {rst_n, psel, penable, pwrite, wob_i, wob_q} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      level = '0;
      miscompares = 0;
      n_compared = 0;
      cycles = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_window();
      t_suppress();
      t_filter();
      t_midrun();
      stop_test();
   end
endmodule // lpts_window_tb_top
